// file: logic/io_ctrl_pkg.sv
// package: register map, field layout and timing of the channel/sequencer control block
// assumes a 25 MHz system clock and a free-running 320 ns conversion oscillator input
package io_ctrl_pkg;
    // clock and timing, times in ns
    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned OSC_PERIOD_NS   = 320;
    localparam int unsigned FAST_CONV_NS    = 208330;    // 4.8 kSPS conversion
    localparam int unsigned SLOW_CONV_NS    = 50000000;  // 20 SPS conversion
    localparam int unsigned RDY_HOLD_NS     = 24000;     // ready pulse in continuous mode
    localparam int unsigned FAST_CONV_TICKS = FAST_CONV_NS / OSC_PERIOD_NS;
    localparam int unsigned SLOW_CONV_TICKS = SLOW_CONV_NS / OSC_PERIOD_NS;
    localparam int unsigned RDY_HOLD_CYC    = RDY_HOLD_NS / CLK_PERIOD_NS;
    // register groups: address bits [7:4], entry in bits [3:2]
    localparam logic [3:0] GRP_MISC  = 4'h0;
    localparam logic [3:0] GRP_ROLE  = 4'h1;
    localparam logic [3:0] GRP_MEAS  = 4'h2;
    localparam logic [3:0] GRP_DIN   = 4'h3;
    localparam logic [3:0] GRP_CODE  = 4'h4;
    localparam logic [3:0] GRP_CHRES = 4'h5;
    localparam logic [3:0] GRP_DGRES = 4'h6;
    // entries of the misc group
    localparam logic [1:0] IDX_EVENT = 2'h0;
    localparam logic [1:0] IDX_LIVE  = 2'h1;
    localparam logic [1:0] IDX_SEQ   = 2'h2;
    localparam logic [1:0] IDX_LOAD  = 2'h3;
    // event flag bits and reset value
    localparam int unsigned EV_POWER_ON = 0;
    localparam int unsigned EV_NEG_SUP  = 1;
    localparam logic [1:0]  EV_RESET    = 2'h3;
    // sequencer control fields
    localparam int unsigned SEQ_CMD_LSB = 8;
    localparam int unsigned SEQ_DRATE   = 10;
    // sequence commands
    localparam logic [1:0] CMD_IDLE   = 2'h0;
    localparam logic [1:0] CMD_SINGLE = 2'h1;
    localparam logic [1:0] CMD_CONT   = 2'h2;
    localparam logic [1:0] CMD_PDOWN  = 2'h3;
    // channel roles
    localparam logic [3:0] ROLE_HIZ   = 4'h0;
    localparam logic [3:0] ROLE_VOUT  = 4'h1;
    localparam logic [3:0] ROLE_IOUT  = 4'h2;
    localparam logic [3:0] ROLE_VIN   = 4'h3;
    localparam logic [3:0] ROLE_IINX  = 4'h4;
    localparam logic [3:0] ROLE_IINL  = 4'h5;
    localparam logic [3:0] ROLE_RES   = 4'h6;
    localparam logic [3:0] ROLE_DIN   = 4'h7;
    localparam logic [3:0] ROLE_DINL  = 4'h8;
    // measurement source and range codes
    localparam logic [1:0] SRC_TERM  = 2'h0;
    localparam logic [1:0] SRC_SENSE = 2'h1;
    localparam logic [2:0] RNG_10V   = 3'h0;
    localparam logic [2:0] RNG_2V5   = 3'h1;
    localparam logic [2:0] RNG_NEG   = 3'h2;
    localparam logic [2:0] RNG_BIP   = 3'h3;
    // measurement setup: [5] slow rate, [4:2] range, [1:0] source
    typedef struct packed {
        logic       slow;
        logic [2:0] range;
        logic [1:0] source;
    } meas_setup_type;
    // logic input setup: [4:1] sink level, [0] comparator enable
    typedef struct packed {
        logic [3:0] sink;
        logic       comp_en;
    } din_setup_type;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } seq_state_type;
endpackage

// file: logic/chan_seq_ctrl.sv
// channel role/preset registers, output code load and conversion sequencer
// assumes an AHB-Lite master on CLOCK, a free conversion oscillator on OSC_CLK
// and converter data on CONV_DATA valid at the end of each conversion
//
// Functional notes
// - power-up sets power-on and supply flags
// - writing one clears an event flag
// - reset leaves every channel high impedance
// - role write loads preset setup registers
// - hi-Z, current out, voltage in: 00/000
// - voltage out presets 01/011
// - external current input presets 01/010
// - loop current 01/001, resistance 00/001
// - digital input roles enable the comparator
// - role change keeps the output code
// - codes reach outputs on load or strobe
// - single: ascending channels, diagnostics, then idle
// - continuous repeats until idle or power-down
// - control holds enables and sequence command
// - sequence end copies results, flags done
// - per-channel rate, one diagnostic rate
// - one request covers any input subset
// - single fast channel repeats every 208.33 us
// - sample-done output is active low
// - done clears on flag, after 24 us in continuous mode, control write
`timescale 1ns/100ps
module chan_seq_ctrl
    import io_ctrl_pkg::*;
#(
    parameter int unsigned SLOW_TICKS = io_ctrl_pkg::SLOW_CONV_TICKS  // 20 SPS conversion, osc ticks
) (
    // clock and reset
    input  wire logic                CLOCK,
    input  wire logic                RST_B,
    // ahb-lite slave
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic      [31:0]         HRDATA,
    output logic                     HREADYOUT,
    output logic                     HRESP,
    // pins from outside the clock domain
    input  wire logic                OSC_CLK,
    input  wire logic                OUTPUT_UPDATE_STROBE_B,
    input  wire logic                NEG_SUPPLY_FAULT,
    // converter side
    input  wire logic [15:0]         CONV_DATA,
    output logic      [2:0]          CONV_SEL,
    output logic                     CONV_BUSY,
    output logic                     SEQ_POWER_DOWN,
    // channel side
    output logic      [3:0]          CH_OUT_EN,
    output logic      [3:0][12:0]    CH_LEVEL,
    output io_ctrl_pkg::meas_setup_type [3:0] CH_MEAS,
    output io_ctrl_pkg::din_setup_type  [3:0] CH_DIN,
    // status pins
    output logic                     ALERT_B,
    output logic                     SAMPLE_DONE_B
);
    import io_ctrl_pkg::*;

    // synchronisers: stage 1 feeds stage 2 only
    logic [2:0]           s1_q;           // first stage
    logic [2:0]           s2_q;           // second stage
    logic                 osc_d3_q;       // delayed osc for edge find
    wire                  osc_tick   = s2_q[0] & ~osc_d3_q;
    wire                  strobe_low = ~s2_q[1];
    wire                  fault_s    = s2_q[2];

    // bus address phase capture
    logic                 sel_q;          // write data phase pending
    logic [7:0]           addr_q;         // captured byte address
    logic [31:0]          rdata_q;        // read data register
    wire                  acc     = HSEL & HTRANS[1] & HREADY;
    wire                  wr_en   = sel_q;
    wire [3:0]            grp     = addr_q[7:4];
    wire [1:0]            ridx    = addr_q[3:2];
    wire                  misc_wr = wr_en & (grp == GRP_MISC);
    wire                  ev_wr   = misc_wr & (ridx == IDX_EVENT);
    wire                  live_wr = misc_wr & (ridx == IDX_LIVE);
    wire                  seq_wr  = misc_wr & (ridx == IDX_SEQ);
    wire                  load_wr = misc_wr & (ridx == IDX_LOAD);

    // register state
    logic [1:0]           ev_q;           // event flags
    logic [10:0]          seq_q;          // sequencer control
    logic [3:0]           role_q [4];     // channel role select
    meas_setup_type       meas_q [4];     // measurement setup
    din_setup_type        din_q  [4];     // logic input setup
    logic [12:0]          code_q [4];     // output level code, pending
    logic [12:0]          act_q  [4];     // output level code, applied
    logic [15:0]          stage_q [8];    // results of running sequence
    logic [15:0]          res_q   [8];    // published sample registers
    logic                 rdy_q;          // sample-done flag
    logic [9:0]           rdy_cnt_q;      // continuous-mode ready timer

    // sequencer
    seq_state_type        st_q;
    logic [2:0]           idx_q;          // input being converted
    logic [17:0]          cnt_q;          // osc ticks into conversion
    wire [1:0]            cmd      = seq_q[SEQ_CMD_LSB +: 2];
    wire [7:0]            en_mask  = seq_q[7:0];
    wire                  run_cmd  = (cmd == CMD_SINGLE) | (cmd == CMD_CONT);
    wire                  cur_slow = idx_q[2] ? seq_q[SEQ_DRATE] : meas_q[idx_q[1:0]].slow;
    wire [17:0]           target   = cur_slow ? 18'(SLOW_TICKS - 1) : 18'(FAST_CONV_TICKS - 1);
    wire                  conv_end = (st_q == ST_CONV) & osc_tick & (cnt_q == target);
    wire [3:0]            first_en = next_en(en_mask, 4'h0);
    wire [3:0]            after_en = next_en(en_mask, {1'b0, idx_q} + 4'h1);
    wire                  done     = (st_q == ST_DONE);

    // lowest enabled input at or above from, 8 when none
    function automatic logic [3:0] next_en(input logic [7:0] m, input logic [3:0] from);
        next_en = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (m[i] && (4'(i) >= from)) begin
                next_en = 4'(i);
            end
        end
    endfunction

    // role presets for source, range and comparator
    function automatic logic [5:0] preset(input logic [3:0] r);
        unique case (r)
            ROLE_VOUT: preset = {RNG_BIP, SRC_SENSE, 1'b0};
            ROLE_IINX: preset = {RNG_NEG, SRC_SENSE, 1'b0};
            ROLE_IINL: preset = {RNG_2V5, SRC_SENSE, 1'b0};
            ROLE_RES:  preset = {RNG_2V5, SRC_TERM,  1'b0};
            ROLE_DIN,
            ROLE_DINL: preset = {RNG_10V, SRC_TERM,  1'b1};
            default:   preset = {RNG_10V, SRC_TERM,  1'b0};
        endcase
    endfunction

    // pin synchronisers and osc edge
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s1_q     <= 3'h2;
            s2_q     <= 3'h2;
            osc_d3_q <= 1'b0;
        end else begin
            s1_q     <= {NEG_SUPPLY_FAULT, OUTPUT_UPDATE_STROBE_B, OSC_CLK};
            s2_q     <= s1_q;
            osc_d3_q <= s2_q[0];
        end
    end

    // read mux, evaluated in the address phase
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (HADDR[7:4])
            GRP_MISC: begin
                unique case (HADDR[3:2])
                    IDX_EVENT: rd_mux = {30'h0000_0000, ev_q};
                    IDX_LIVE:  rd_mux = {31'h0000_0000, rdy_q};
                    IDX_SEQ:   rd_mux = {21'h00_0000, seq_q};
                    default:   rd_mux = 32'h0000_0000;
                endcase
            end
            GRP_ROLE:  rd_mux = {28'h000_0000, role_q[HADDR[3:2]]};
            GRP_MEAS:  rd_mux = {26'h000_0000, meas_q[HADDR[3:2]]};
            GRP_DIN:   rd_mux = {27'h000_0000, din_q[HADDR[3:2]]};
            GRP_CODE:  rd_mux = {19'h0_0000, code_q[HADDR[3:2]]};
            GRP_CHRES: rd_mux = {16'h0000, res_q[{1'b0, HADDR[3:2]}]};
            GRP_DGRES: rd_mux = {16'h0000, res_q[{1'b1, HADDR[3:2]}]};
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // bus phase capture, zero-wait slave
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            sel_q   <= 1'b0;
            addr_q  <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            sel_q <= acc & HWRITE & (HADDR[31:8] == 24'h00_0000);
            if (acc) begin
                addr_q <= HADDR[7:0];
            end
            if (acc && !HWRITE) begin
                rdata_q <= (HADDR[31:8] == 24'h00_0000) ? rd_mux : 32'h0000_0000;
            end
        end
    end
    assign HRDATA    = rdata_q;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // event flags: set at reset, fault sets, write-one clears, set wins
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ev_q <= EV_RESET;
        end else begin
            ev_q <= (ev_q & ~(ev_wr ? HWDATA[1:0] : 2'h0))
                  | {fault_s, 1'b0};
        end
    end
    assign ALERT_B = ~|ev_q;

    // sequencer control, single command returns to idle at sequence end
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            seq_q <= 11'h000;
        end else if (seq_wr) begin
            seq_q <= HWDATA[10:0];
        end else if (done && cmd == CMD_SINGLE) begin
            seq_q[SEQ_CMD_LSB +: 2] <= CMD_IDLE;
        end
    end
    assign SEQ_POWER_DOWN = (cmd == CMD_PDOWN) & (st_q == ST_IDLE);

    // per-channel setup, codes and output load
    for (genvar c = 0; c < 4; c++) begin : g_ch
        wire sel_c   = (ridx == 2'(c));
        wire role_wr = wr_en & (grp == GRP_ROLE) & sel_c;
        wire meas_wr = wr_en & (grp == GRP_MEAS) & sel_c;
        wire din_wr  = wr_en & (grp == GRP_DIN) & sel_c;
        wire code_wr = wr_en & (grp == GRP_CODE) & sel_c;
        wire [5:0] pre = preset(HWDATA[3:0]);
        // role write loads presets, keeps the slow rate bit, clears sink level
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                role_q[c] <= ROLE_HIZ;
                meas_q[c] <= '0;
                din_q[c]  <= '0;
            end else if (role_wr) begin
                role_q[c] <= HWDATA[3:0];
                meas_q[c] <= {meas_q[c].slow, pre[5:1]};
                din_q[c]  <= {4'h0, pre[0]};
            end else begin
                if (meas_wr) begin
                    meas_q[c] <= HWDATA[5:0];
                end
                if (din_wr) begin
                    din_q[c] <= HWDATA[4:0];
                end
            end
        end
        // code untouched by role writes; applied on load or strobe low
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                code_q[c] <= 13'h0000;
                act_q[c]  <= 13'h0000;
            end else begin
                if (code_wr) begin
                    code_q[c] <= HWDATA[12:0];
                end
                if (load_wr || strobe_low) begin
                    act_q[c] <= code_q[c];
                end
            end
        end
        assign CH_OUT_EN[c] = (role_q[c] != ROLE_HIZ);
        assign CH_LEVEL[c]  = act_q[c];
        assign CH_MEAS[c]   = meas_q[c];
        assign CH_DIN[c]    = din_q[c];
    end

    // conversion sequencer
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            st_q  <= ST_IDLE;
            idx_q <= 3'h0;
            cnt_q <= 18'h0_0000;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (run_cmd && !first_en[3]) begin
                        st_q  <= ST_CONV;
                        idx_q <= first_en[2:0];
                        cnt_q <= 18'h0_0000;
                    end
                end
                ST_CONV: begin
                    if (conv_end) begin
                        cnt_q <= 18'h0_0000;
                        if (after_en[3]) begin
                            st_q <= ST_DONE;
                        end else begin
                            idx_q <= after_en[2:0];
                        end
                    end else if (osc_tick) begin
                        cnt_q <= cnt_q + 18'h0_0001;
                    end
                end
                ST_DONE: begin
                    if (cmd == CMD_CONT && !first_en[3]) begin
                        st_q  <= ST_CONV;
                        idx_q <= first_en[2:0];
                    end else begin
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    assign CONV_SEL  = idx_q;
    assign CONV_BUSY = (st_q == ST_CONV);

    // staging and publishing of results
    for (genvar e = 0; e < 8; e++) begin : g_res
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                stage_q[e] <= 16'h0000;
                res_q[e]   <= 16'h0000;
            end else begin
                if (conv_end && idx_q == 3'(e)) begin
                    stage_q[e] <= CONV_DATA;
                end
                if (done) begin
                    res_q[e] <= stage_q[e];
                end
            end
        end
    end

    // sample-done: set at sequence end wins over every clear
    wire rdy_tout = (cmd == CMD_CONT) & (rdy_cnt_q == 10'(RDY_HOLD_CYC - 1));
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rdy_q     <= 1'b0;
            rdy_cnt_q <= 10'h000;
        end else begin
            rdy_cnt_q <= (rdy_q && !done) ? rdy_cnt_q + 10'h001 : 10'h000;
            if (done) begin
                rdy_q <= 1'b1;
            end else if ((live_wr && HWDATA[0]) || seq_wr || rdy_tout) begin
                rdy_q <= 1'b0;
            end
        end
    end
    assign SAMPLE_DONE_B = ~rdy_q;

    // checks
    clear_needs_write_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $fell(ev_q[EV_POWER_ON]) |-> $past(ev_wr && HWDATA[EV_POWER_ON]))
        else $error("power-on flag cleared without a write of one");
    alert_release_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (ev_wr && HWDATA[1:0] == 2'h3 && !fault_s) |=> ALERT_B)
        else $error("alert stays low after all flags cleared");
    preset_load_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        g_ch[0].role_wr |=> meas_q[0][4:0] == $past(g_ch[0].pre[5:1]) && din_q[0].comp_en == $past(g_ch[0].pre[0]))
        else $error("role write did not load presets");
    code_kept_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (g_ch[0].role_wr && !g_ch[0].code_wr) |=> $stable(code_q[0]))
        else $error("role write changed output code");
    load_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (!strobe_low && !load_wr) |=> $stable(CH_LEVEL))
        else $error("output level moved without load");
    hiz_role_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (g_ch[0].role_wr && HWDATA[3:0] == ROLE_HIZ) |=> !CH_OUT_EN[0])
        else $error("hi-Z role left output enabled");
    ascend_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (st_q == ST_CONV && $past(st_q) == ST_CONV && $changed(idx_q)) |-> idx_q > $past(idx_q))
        else $error("sequence order not ascending");
    publish_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        done |=> !SAMPLE_DONE_B && res_q[4] == $past(stage_q[4]))
        else $error("results not published with ready");
    repeat_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (done && cmd == CMD_CONT && en_mask != 8'h00) |=> st_q == ST_CONV)
        else $error("continuous mode did not repeat");
    ready_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (rdy_q && seq_wr && !done) |=> SAMPLE_DONE_B)
        else $error("control write did not clear ready");
endmodule

// file: dv/conv_front_model.sv
// converter front end model: free oscillator and one result per input
// assumes CONV_SEL comes from the sequencer in the system clock domain
`timescale 1ns/100ps
module conv_front_model (
    // oscillator
    output logic             OSC_CLK,
    // converter
    input  wire logic [2:0]  CONV_SEL,
    output logic      [15:0] CONV_DATA
);
    // free-running 320 ns oscillator
    initial OSC_CLK = 1'b0;
    always #160 OSC_CLK = ~OSC_CLK;
    // result carries the input number in its low bits
    assign CONV_DATA = {13'h0AB5, CONV_SEL};
endmodule

// file: dv/test_chan_seq_ctrl.sv
// bench: ahb-lite register tasks and directed checks of chan_seq_ctrl
// assumes conv_front_model supplies oscillator and converter results
`timescale 1ns/100ps
module test_chan_seq_ctrl;
    import io_ctrl_pkg::*;
    logic                 clock = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, strobe_b = 1'b1, fault = 1'b0;
    logic [31:0]          haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]           htrans = 2'h0;
    logic [2:0]           conv_sel;
    logic [15:0]          conv_data;
    logic                 hreadyout, hresp, osc_clk, busy, pdown, alert_b, done_b;
    logic [3:0]           out_en;
    logic [3:0][12:0]     level;
    meas_setup_type [3:0] meas;
    din_setup_type  [3:0] din;
    logic [2:0]           seen[$];  // inputs in conversion order
    int                   n_errors = 0, n_checks = 0, cyc = 0, i;
    realtime              t_prev, t_fall, t_rise;
    chan_seq_ctrl #(.SLOW_TICKS(20)) dut (.CLOCK(clock), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .OSC_CLK(osc_clk),
        .OUTPUT_UPDATE_STROBE_B(strobe_b), .NEG_SUPPLY_FAULT(fault), .CONV_DATA(conv_data),
        .CONV_SEL(conv_sel), .CONV_BUSY(busy), .SEQ_POWER_DOWN(pdown), .CH_OUT_EN(out_en),
        .CH_LEVEL(level), .CH_MEAS(meas), .CH_DIN(din), .ALERT_B(alert_b), .SAMPLE_DONE_B(done_b));
    conv_front_model model (.OSC_CLK(osc_clk), .CONV_SEL(conv_sel), .CONV_DATA(conv_data));
    // 25 MHz clock
    always #20 clock = ~clock;
    // hang guard and conversion order log
    always @(posedge clock) begin
        cyc++;
        if (busy === 1'b1 && (seen.size() == 0 || seen[$] !== conv_sel))
            seen.push_back(conv_sel);
        if (cyc == 90000) begin
            n_errors++;
            stop_test();
        end
    end
    // sample-done edge times
    always @(negedge done_b) begin
        t_prev = t_fall;
        t_fall = $realtime;
    end
    always @(posedge done_b) t_rise = $realtime;
    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one single ahb transfer, read data kept in rd
    task automatic xfer(input logic w, input logic [31:0] a, d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen_v, exp);
        n_checks++;
        if (seen_v !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
        end
    endtask
    task automatic rdchk(input string nm, input logic [31:0] a, exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, rd, exp);
        chk("hresp", hresp, 32'h0);
    endtask
    // bounded wait for a sample-done level
    task automatic wait_done(input logic v, input int lim);
        for (i = 0; i < lim && done_b !== v; i++) @(posedge clock);
    endtask
    // role presets as {comparator, range, source}
    function automatic logic [5:0] preset(input int r);
        case (r)
            1: return 6'h0D;
            4: return 6'h09;
            5: return 6'h05;
            6: return 6'h04;
            7, 8: return 6'h20;
            default: return 6'h00;
        endcase
    endfunction
    initial begin
        repeat (20) @(posedge clock); // power-up wait, shortened
        rst_b <= 1'b1;
        rdchk("event", 32'h0, 32'h3);
        chk("alert", alert_b, 32'h0);
        chk("out_en", out_en, 32'h0);
        xfer(1'b1, 32'h0, 32'h1);
        rdchk("event", 32'h0, 32'h2);
        xfer(1'b1, 32'h0, 32'h3);
        rdchk("event", 32'h0, 32'h0);
        chk("alert", alert_b, 32'h1);
        // fault pin held high: its flag survives a clear
        fault <= 1'b1;
        repeat (4) @(posedge clock);
        xfer(1'b1, 32'h0, 32'h3);
        rdchk("event", 32'h0, 32'h2);
        chk("alert", alert_b, 32'h0);
        fault <= 1'b0;
        repeat (4) @(posedge clock);
        xfer(1'b1, 32'h0, 32'h3);
        rdchk("event", 32'h0, 32'h0);
        chk("alert", alert_b, 32'h1);
        // every role on channel 0, code left pending
        xfer(1'b1, 32'h40, 32'h1234);
        for (int r = 0; r < 9; r++) begin
            xfer(1'b1, 32'h10, r);
            rdchk("meas", 32'h20, 32'(preset(r) & 6'h1F));
            rdchk("din", 32'h30, 32'(preset(r) >> 5));
            repeat (3750) @(posedge clock);
        end
        chk("out_en", out_en, 32'h1);
        chk("meas_pin", meas[0], 32'h0);
        chk("din_pin", din[0], 32'h1);
        rdchk("code", 32'h40, 32'h1234);
        chk("level0", level[0], 32'h0);
        xfer(1'b1, 32'hC, 32'h0);
        repeat (3) @(posedge clock);
        chk("level0", level[0], 32'h1234);
        xfer(1'b1, 32'h44, 32'h55);
        repeat (3) @(posedge clock);
        chk("level1", level[1], 32'h0);
        strobe_b <= 1'b0;
        repeat (6) @(posedge clock);
        chk("level1", level[1], 32'h55);
        strobe_b <= 1'b1;
        // single: ch0, ch2, diag0
        seen.delete();
        xfer(1'b1, 32'h8, 32'h115);
        wait_done(1'b0, 20000);
        chk("done", done_b, 32'h0);
        chk("order", 32'({seen.size() == 3, seen[0], seen[1], seen[2]}), 32'h214);
        rdchk("ch0", 32'h50, 32'h55A8);
        rdchk("ch1", 32'h54, 32'h0);
        rdchk("ch2", 32'h58, 32'h55AA);
        rdchk("dg0", 32'h60, 32'h55AC);
        rdchk("cmd", 32'h8, 32'h15);
        xfer(1'b1, 32'h4, 32'h1);
        repeat (2) @(posedge clock);
        chk("done", done_b, 32'h1);
        // slow rate on ch1 ends far sooner than a fast conversion
        xfer(1'b1, 32'h24, 32'h20);
        xfer(1'b1, 32'h8, 32'h512);
        wait_done(1'b0, 600);
        chk("slow", done_b, 32'h0);
        xfer(1'b1, 32'h8, 32'h0);
        repeat (2) @(posedge clock);
        chk("done", done_b, 32'h1);
        // continuous, ch0 fast
        xfer(1'b1, 32'h8, 32'h201);
        wait_done(1'b0, 20000);
        wait_done(1'b1, 1000);
        chk("width", 32'(int'(t_rise - t_fall)), 32'd24000);
        wait_done(1'b0, 20000);
        chk("period", 32'(t_fall - t_prev > 206247 && t_fall - t_prev < 210413), 32'h1);
        xfer(1'b1, 32'h8, 32'h0);
        repeat (2) @(posedge clock);
        chk("done", done_b, 32'h1);
        chk("busy", busy, 32'h1);
        repeat (6000) @(posedge clock);
        chk("busy", busy, 32'h0);
        xfer(1'b1, 32'h8, 32'h300);
        repeat (2) @(posedge clock);
        chk("pdown", pdown, 32'h1);
        xfer(1'b1, 32'h100, 32'hFF);
        rdchk("unmapped", 32'h100, 32'h0);
        rdchk("load", 32'hC, 32'h0);
        // back to hi-Z after a held role: output off, code kept
        xfer(1'b1, 32'h10, 32'h0);
        repeat (2) @(posedge clock);
        chk("out_en", out_en, 32'h0);
        rdchk("code", 32'h40, 32'h1234);
        stop_test();
    end
endmodule
